// [rtl/rbcm_top.sv]
// Reset qualification, reset stretch and boot clock mode capture
`timescale 1ns/100ps
`default_nettype none
`include "rbcm_defs.svh"
module rbcm_top
#(
  parameter int unsigned MIN_LOW = `RBCM_RST_FILTER_CYCLES,
  parameter int unsigned STRETCH = `RBCM_RESET_INDICATION_OUT_N_STRETCH_CYCLES,
  parameter int unsigned REF_CLK_HZ = 16000000,
  parameter int unsigned DIV_W = 4
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_input_n,
  input wire logic [1:0] boot_clock_select,
  input wire logic crystal_drive_pin_in,
  output logic crystal_drive_pin_out,
  output logic crystal_drive_pin_oe,
  input wire logic reset_config_n,
  input wire logic test_pin,
  output logic cpu_periph_reset,
  output logic reset_indication_out_n,
  output rbcm_pkg::rbcm_clk_src_t boot_clock_source,
  output logic pll_enable,
  output logic [DIV_W-1:0] pll_ref_divider,
  output logic pll_ref_out_of_range,
  output logic boot_mode_reserved,
  output logic flash_prog_mode,
  output logic system_clock_mirror
);
  import rbcm_pkg::*;

  localparam int SW = $clog2(STRETCH);
  localparam logic [SW-1:0] STRETCH_LAST = SW'(STRETCH - 1);
  // The source must lie strictly above divider times the lower bound
  localparam logic REF_BAD =
    (REF_CLK_HZ <= `RBCM_PLL_PREDIV_RESET * `RBCM_PLL_REF_MIN_HZ) ||
    (REF_CLK_HZ > `RBCM_PLL_PREDIV_RESET * `RBCM_PLL_REF_MAX_HZ);

  logic reset_req;
  rbcm_state_t state;
  logic [SW-1:0] stretch_cnt;
  logic [1:0] sel_q;
  logic crystal_drive_pin_q;
  logic release_now;

  rbcm_boot_if boot ();

  // ==========================================================================
  // Reset source qualification
  rbcm_reset_filter #(.MIN_LOW(MIN_LOW)) u_filter
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reset_input_n(reset_input_n),
    .reset_req(reset_req)
  );

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cpu_periph_reset <= 1'b1;
    else
      cpu_periph_reset <= reset_req;
  end

  // ==========================================================================
  // Reset sequence: hold while a source is active, then stretch
  assign release_now = (state == RBCM_ST_HOLD) && !reset_req;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= RBCM_ST_HOLD;
      stretch_cnt <= '0;
      reset_indication_out_n <= 1'b0;
    end
    else if (reset_req)
    begin
      // A new qualified reset restarts the whole sequence at any time
      state <= RBCM_ST_HOLD;
      stretch_cnt <= '0;
      reset_indication_out_n <= 1'b0;
    end
    else
    begin
      case (state)
        RBCM_ST_HOLD:
        begin
          state <= RBCM_ST_STRETCH;
          stretch_cnt <= '0;
        end
        RBCM_ST_STRETCH:
        begin
          if (stretch_cnt == STRETCH_LAST)
          begin
            state <= RBCM_ST_RUN;
            reset_indication_out_n <= 1'b1;
          end
          else
            stretch_cnt <= stretch_cnt + 1'b1;
        end
        RBCM_ST_RUN:
          state <= RBCM_ST_RUN;
        default:
          state <= RBCM_ST_HOLD;
      endcase
    end
  end

  // ==========================================================================
  // Strap capture at the end of the reset source
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_q <= `RBCM_SEL_DIRECT;
      crystal_drive_pin_q <= 1'b0;
    end
    else if (release_now)
    begin
      sel_q <= boot_clock_select;
      // The crystal pin only means something when it is not oscillating
      crystal_drive_pin_q <= boot_clock_select[0] ? 1'b0 : crystal_drive_pin_in;
    end
  end

  assign boot.sel = sel_q;
  assign boot.crystal_drive_pin = crystal_drive_pin_q;

  rbcm_mode_decode u_decode
  (
    .boot(boot)
  );

  // Decoded mode is registered so it stays frozen until the next reset
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_clock_source <= RBCM_SRC_EXT_OSC;
      pll_enable <= 1'b0;
      boot_mode_reserved <= 1'b0;
      pll_ref_out_of_range <= 1'b0;
    end
    else
    begin
      boot_clock_source <= boot.src;
      pll_enable <= boot.pll_en;
      boot_mode_reserved <= boot.reserved;
      // Reference must land inside the PLL input range after predivide
      pll_ref_out_of_range <= boot.pll_en && REF_BAD;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pll_ref_divider <= DIV_W'(`RBCM_PLL_PREDIV_RESET);
    else
      pll_ref_divider <= DIV_W'(`RBCM_PLL_PREDIV_RESET);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      flash_prog_mode <= 1'b0;
    else if (release_now)
      flash_prog_mode <= !reset_config_n && !test_pin;
  end

  // ==========================================================================
  // Crystal pin direction; the amplifier itself is analog and outside
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crystal_drive_pin_oe <= 1'b0;
      crystal_drive_pin_out <= 1'b0;
    end
    else
    begin
      // While the sequence is in RBCM_ST_HOLD follow the live strap so the pin can be sampled
      crystal_drive_pin_oe <= (state == RBCM_ST_HOLD) ?
                              boot_clock_select[0] : sel_q[0];
      crystal_drive_pin_out <= 1'b0;
    end
  end

  // A flop cannot copy its own clock, so the mirror is a direct wire
  assign system_clock_mirror = sys_clk;

  // ==========================================================================
  // Checks
  logic [SW:0] stretch_len;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      stretch_len <= '0;
    else if (state == RBCM_ST_STRETCH)
      stretch_len <= stretch_len + 1'b1;
    else
      stretch_len <= '0;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  reset_qualify_a: assert property (
    (!reset_input_n) [*8] |-> ##2 cpu_periph_reset)
    else $error("qualified reset did not reach the core");

  stretch_length_a: assert property (
    $rose(reset_indication_out_n) |-> stretch_len == (SW+1)'(STRETCH))
    else $error("reset indication stretch has the wrong length");

  stretch_held_a: assert property (
    cpu_periph_reset |=> !reset_indication_out_n)
    else $error("reset indication released while in reset");

  direct_mode_a: assert property (
    (sel_q == `RBCM_SEL_DIRECT) |=>
      !pll_enable && boot_clock_source ==
        ($past(crystal_drive_pin_q) ? RBCM_SRC_ONCHIP : RBCM_SRC_EXT_OSC))
    else $error("direct clock mode decoded wrongly");

  onchip_mode_a: assert property (
    (sel_q == `RBCM_SEL_DIRECT && crystal_drive_pin_q) ##1 1'b1 |->
      boot_clock_source == RBCM_SRC_ONCHIP && !pll_enable)
    else $error("on-chip oscillator mode decoded wrongly");

  crystal_drive_pin_bypass_a: assert property (
    (sel_q == `RBCM_SEL_CRYSTAL_DRIVE_PIN_BYPASS) |=>
      boot_clock_source == RBCM_SRC_CRYSTAL && !pll_enable)
    else $error("crystal bypass mode decoded wrongly");

  pll_ext_a: assert property (
    (sel_q == `RBCM_SEL_PLL_EXT && !crystal_drive_pin_q) |=>
      boot_clock_source == RBCM_SRC_EXT_OSC && pll_enable)
    else $error("PLL external oscillator mode decoded wrongly");

  pll_crystal_drive_pin_a: assert property (
    (sel_q == `RBCM_SEL_PLL_CRYSTAL_DRIVE_PIN) |=>
      boot_clock_source == RBCM_SRC_CRYSTAL && pll_enable)
    else $error("PLL crystal mode decoded wrongly");

  crystal_drive_pin_dir_a: assert property (
    (state == RBCM_ST_RUN) |-> crystal_drive_pin_oe == sel_q[0])
    else $error("crystal pin direction does not follow the strap");

  prediv_value_a: assert property (
    pll_ref_divider == DIV_W'(`RBCM_PLL_PREDIV_RESET))
    else $error("PLL reference divider is not at its reset ratio");

  flash_entry_a: assert property (
    release_now |=> flash_prog_mode ==
      (!$past(reset_config_n) && !$past(test_pin)))
    else $error("flash programming mode not taken from straps");

  mode_frozen_a: assert property (
    (state == RBCM_ST_RUN) ##1 (state == RBCM_ST_RUN) |->
      $stable(sel_q) && $stable(flash_prog_mode))
    else $error("boot mode changed outside reset");

  // Reset release, strap capture and flag sanity
  reset_release_a: assert property (
    reset_input_n ##1 reset_input_n |=> !cpu_periph_reset)
    else $error("core reset held after the pin went high");

  sel_capture_a: assert property (
    release_now |=> sel_q == $past(boot_clock_select))
    else $error("clock select strap not captured at release");

  crystal_drive_pin_capture_a: assert property (
    release_now && !boot_clock_select[0] |=>
      crystal_drive_pin_q == $past(crystal_drive_pin_in))
    else $error("crystal pin strap not sampled at release");

  reserved_flag_a: assert property (
    1'b1 |=> boot_mode_reserved ==
      ($past(sel_q) == `RBCM_SEL_PLL_EXT && $past(crystal_drive_pin_q)))
    else $error("reserved strap flag does not match the strap");

  ref_range_a: assert property (
    pll_ref_out_of_range |-> pll_enable)
    else $error("PLL reference flagged while the PLL is off");

  cover_run_c: cover property ($rose(reset_indication_out_n));
  cover_bypass_c: cover property (!pll_enable && state == RBCM_ST_RUN);
  cover_flash_c: cover property (release_now ##1 flash_prog_mode);
  cover_reserved_c: cover property (boot_mode_reserved);
  cover_pll_c: cover property (pll_enable && state == RBCM_ST_RUN);
endmodule
`default_nettype wire

// [rtl/rbcm_defs.svh]
// Constants for the reset and boot clock mode block
`ifndef RBCM_DEFS_SVH
`define RBCM_DEFS_SVH

// ==========================================================================
// Timing counts, in CPU clock cycles
`define RBCM_RST_FILTER_CYCLES 8
`define RBCM_RESET_INDICATION_OUT_N_STRETCH_CYCLES 1024

// ==========================================================================
// PLL reference divider and reference range
`define RBCM_PLL_PREDIV_RESET 6
`define RBCM_PLL_REF_MIN_HZ 2000000
`define RBCM_PLL_REF_MAX_HZ 10000000

// ==========================================================================
// Clock select codes
`define RBCM_SEL_DIRECT 2'b00
`define RBCM_SEL_CRYSTAL_DRIVE_PIN_BYPASS 2'b01
`define RBCM_SEL_PLL_EXT 2'b10
`define RBCM_SEL_PLL_CRYSTAL_DRIVE_PIN 2'b11

`endif

// [rtl/rbcm_pkg.sv]
// Types shared by the reset and boot clock mode block
package rbcm_pkg;

  typedef enum logic [1:0]
  {
    RBCM_SRC_EXT_OSC = 2'b00,
    RBCM_SRC_ONCHIP = 2'b01,
    RBCM_SRC_CRYSTAL = 2'b10
  } rbcm_clk_src_t;

  typedef enum logic [1:0]
  {
    RBCM_ST_HOLD = 2'b00,
    RBCM_ST_STRETCH = 2'b01,
    RBCM_ST_RUN = 2'b10
  } rbcm_state_t;

endpackage

// [rtl/rbcm_boot_if.sv]
// Strap levels in, decoded boot clock mode out
`timescale 1ns/100ps
`default_nettype none
interface rbcm_boot_if;
  import rbcm_pkg::*;
  logic [1:0] sel;
  logic crystal_drive_pin;
  rbcm_clk_src_t src;
  logic pll_en;
  logic reserved;

  modport decoder
  (
    input sel,
    input crystal_drive_pin,
    output src,
    output pll_en,
    output reserved
  );

  modport owner
  (
    output sel,
    output crystal_drive_pin,
    input src,
    input pll_en,
    input reserved
  );
endinterface
`default_nettype wire

// [rtl/rbcm_reset_filter.sv]
// Qualifies the external reset input by a run of low samples
`timescale 1ns/100ps
`default_nettype none
`include "rbcm_defs.svh"
module rbcm_reset_filter
#(
  parameter int unsigned MIN_LOW = `RBCM_RST_FILTER_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_input_n,
  output logic reset_req
);
  import rbcm_pkg::*;

  localparam int CW = $clog2(MIN_LOW + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_LOW - 1);

  logic [CW-1:0] low_cnt;

  // ==========================================================================
  // Run length of low samples; a single high sample restarts the run
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_cnt <= '0;
    else if (reset_input_n)
      low_cnt <= '0;
    else if (low_cnt != LAST)
      low_cnt <= low_cnt + 1'b1;
  end

  // Short glitches never reach the core; the request drops with the pin
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reset_req <= 1'b0;
    else if (reset_input_n)
      reset_req <= 1'b0;
    else if (low_cnt == LAST)
      reset_req <= 1'b1;
  end
endmodule
`default_nettype wire

// [rtl/rbcm_mode_decode.sv]
// Decodes clock select and crystal pin into a boot clock mode
`timescale 1ns/100ps
`default_nettype none
`include "rbcm_defs.svh"
module rbcm_mode_decode
(
  rbcm_boot_if.decoder boot
);
  import rbcm_pkg::*;

  function automatic logic [3:0] decode(input logic [1:0] sel,
                                        input logic crystal_drive_pin);
    logic [3:0] r;
    r = {1'b0, 1'b0, RBCM_SRC_EXT_OSC};
    case (sel)
      `RBCM_SEL_DIRECT:
        r = crystal_drive_pin ? {1'b0, 1'b0, RBCM_SRC_ONCHIP}
                 : {1'b0, 1'b0, RBCM_SRC_EXT_OSC};
      `RBCM_SEL_CRYSTAL_DRIVE_PIN_BYPASS:
        r = {1'b0, 1'b0, RBCM_SRC_CRYSTAL};
      // Reserved strap falls back to a safe PLL-bypassed on-chip clock
      `RBCM_SEL_PLL_EXT:
        r = crystal_drive_pin ? {1'b1, 1'b0, RBCM_SRC_ONCHIP}
                 : {1'b0, 1'b1, RBCM_SRC_EXT_OSC};
      `RBCM_SEL_PLL_CRYSTAL_DRIVE_PIN:
        r = {1'b0, 1'b1, RBCM_SRC_CRYSTAL};
      default:
        r = {1'b0, 1'b0, RBCM_SRC_EXT_OSC};
    endcase
    return r;
  endfunction

  logic [3:0] res;
  assign res = decode(boot.sel, boot.crystal_drive_pin);
  assign boot.reserved = res[3];
  assign boot.pll_en = res[2];
  assign boot.src = rbcm_clk_src_t'(res[1:0]);
endmodule
`default_nettype wire

// [tb/rbcm_board.sv]
// Board model: reset button, clock straps and programmer strap
`timescale 1ns/100ps
`default_nettype none
module rbcm_board
(
  input wire logic sys_clk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic reset_input_n,
  output logic [1:0] boot_clock_select,
  output logic pin_level,
  output logic reset_config_n,
  output logic test_pin
);
  logic crystal_drive_pin_strap;
  initial
  begin
    reset_input_n = 1'b1;
    boot_clock_select = 2'b00;
    crystal_drive_pin_strap = 1'b0;
    reset_config_n = 1'b1;
    test_pin = 1'b0;
  end
  // ====
  // Crystal pin is a strap only while the device leaves it undriven
  assign pin_level = pin_oe ? pin_out : crystal_drive_pin_strap;
  task automatic strap(input logic [1:0] s, input logic x,
    input logic rc, input logic t);
    boot_clock_select <= s;
    // Reserved select 10 with crystal high is never strapped
    crystal_drive_pin_strap <= (s == 2'b10) ? 1'b0 : x;
    reset_config_n <= rc;
    test_pin <= t;
  endtask
  // Straps settle with the press and stay until after release
  task automatic press(input logic [1:0] s, input logic x,
    input logic rc, input logic t, input int lows);
    @(posedge sys_clk);
    strap(s, x, rc, t);
    reset_input_n <= 1'b0;
    repeat (lows) @(posedge sys_clk);
    reset_input_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the reset and boot clock mode block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rbcm_pkg::*;
  localparam int unsigned MIN_LOW = 8;
  localparam int unsigned STRETCH = 16;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_n, pin, oe, pout, rcn, tst, cpu_rst, ind_n, pll, oor;
  logic resv, flash, mirror, hit;
  logic [1:0] sel;
  logic [3:0] div;
  rbcm_clk_src_t src;
  int err_count = 0;
  int checked = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cpu_rst === 1'b1) hit <= 1'b1;
  rbcm_board i_rbcm_board (.sys_clk(sys_clk), .pin_oe(oe),
    .pin_out(pout), .reset_input_n(rst_n), .boot_clock_select(sel),
    .pin_level(pin), .reset_config_n(rcn), .test_pin(tst));
  rbcm_top #(.MIN_LOW(MIN_LOW), .STRETCH(STRETCH),
    .REF_CLK_HZ(12000000), .DIV_W(4)) i_rbcm_top (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reset_input_n(rst_n), .boot_clock_select(sel),
    .crystal_drive_pin_in(pin), .crystal_drive_pin_out(pout),
    .crystal_drive_pin_oe(oe), .reset_config_n(rcn), .test_pin(tst),
    .cpu_periph_reset(cpu_rst), .reset_indication_out_n(ind_n),
    .boot_clock_source(src), .pll_enable(pll), .pll_ref_divider(div),
    .pll_ref_out_of_range(oor), .boot_mode_reserved(resv),
    .flash_prog_mode(flash), .system_clock_mirror(mirror));
  // ====
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Source, PLL enable, crystal drive enable, reserved flag
  function automatic logic [4:0] exp_mode(input logic [1:0] s,
    input logic x);
    logic [1:0] c;
    c = s[0] ? 2'b10 : (x ? 2'b01 : 2'b00);
    return {c, s[1], s[0], 1'b0};
  endfunction
  // ====
  task automatic boot(input logic [1:0] s, input logic x,
    input logic rc, input logic t, input int lows);
    int n;
    n = 0;
    hit = 1'b0;
    i_rbcm_board.press(s, x, rc, t, lows);
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (ind_n !== 1'b1 && n < 300);
    check("reset seen", {15'h0, hit}, 16'h1);
    check("stretch", 16'(n), 16'(STRETCH + 2));
    check("cpu reset", {15'h0, cpu_rst}, 16'h0);
    // Later strap changes must not reach the captured mode
    i_rbcm_board.strap(~s, ~x, ~rc, ~t);
    repeat (3) @(posedge sys_clk);
    #1;
    check("mode", {src, pll, oe, resv},
      exp_mode(s, x));
    check("divider", {div, oor}, {4'h6, s[1]});
    check("flash", {flash, pout}, {~rc & ~t, 1'b0});
    check("mirror high", {15'h0, mirror}, 16'h1);
    #50;
    check("mirror low", {15'h0, mirror}, 16'h0);
  endtask
  initial
  begin
    logic [1:0] s;
    logic x;
    void'($urandom(32'h7c6d53e8));
    hit = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check("in reset", {cpu_rst, ind_n, flash, div}, 7'h46);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      if (i != 5)
        boot(i[2:1], i[0], 1'b0, 1'b0, MIN_LOW + 4);
    repeat (12)
    begin
      s = 2'($urandom);
      x = (s == 2'b10) ? 1'b0 : 1'($urandom);
      boot(s, x, 1'($urandom), 1'($urandom),
        MIN_LOW + $urandom_range(0, 6));
    end
    boot(2'b11, 1'b0, 1'b0, 1'b1, MIN_LOW);
    // One sample short of qualifying must leave the chip running
    hit = 1'b0;
    i_rbcm_board.press(2'b10, 1'b0, 1'b0, 1'b0, MIN_LOW - 1);
    repeat (6) @(posedge sys_clk);
    #1;
    check("short pulse", {hit, ind_n}, 2'b01);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    #1;
    check("async reset", {cpu_rst, ind_n}, 2'b10);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (STRETCH + 6) @(posedge sys_clk);
    #1;
    check("after reset", {cpu_rst, ind_n}, 2'b01);
    wrap_up;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
